// [pkg/cspc_pkg.sv]
// Purpose: shared constants and types of the clocked serial port control block
// Assumes: apb with 32-bit data, register byte address = 4 * register index
// Notes:   index values are the printed register numbers
package cspc_pkg;
	localparam int          ADDR_W          = 16;
	localparam logic [11:0] IDX_FLAGS       = 12'h003; // done flag in bit 2, state in 5:4
	localparam logic [11:0] IDX_PORT_MODE_A = 12'h004;
	localparam logic [11:0] IDX_SERIAL_A    = 12'h005;
	localparam logic [11:0] IDX_SHIFT_LOW   = 12'h006;
	localparam logic [11:0] IDX_SHIFT_HIGH  = 12'h007;
	localparam logic [11:0] IDX_MISC_PIN    = 12'h00c;
	localparam logic [11:0] IDX_SERIAL_B    = 12'h028;
	localparam logic [11:0] IDX_START       = 12'h030; // start_transfer_instr on any write
	localparam int          FLAG_DONE_BIT   = 2;
	localparam int          FLAG_STATE_LSB  = 4;
	localparam logic [3:0]  SERIAL_A_RST    = 4'h0;
	localparam logic [1:0]  PORT_MODE_RST   = 2'h0;
	localparam logic [1:0]  MISC_PIN_RST    = 2'h0;
	localparam logic [1:0]  SERIAL_B_RST    = 2'h0;
	localparam logic [1:0]  SERIAL_A_DLY    = 2'h2; // cycles until a new mode value acts
	localparam int          HALF_LOG_MAX    = 11;   // half period at divider code 0 with smb[0] low, log2 cycles
	localparam logic [2:0]  LAST_BIT        = 3'h7;
	localparam logic [2:0]  EXT_CLK_CODE    = 3'h6; // codes 6 and 7 take the clock from the pin

	typedef enum logic [1:0] {
		CSPC_WAIT_START = 2'b00,
		CSPC_WAIT_CLK   = 2'b01,
		CSPC_XFER       = 2'b10,
		CSPC_CONT       = 2'b11
	} cspc_state_t;

	typedef enum logic [1:0] {
		CSPC_MODE_CONT = 2'b00,
		CSPC_MODE_TX   = 2'b01,
		CSPC_MODE_RX   = 2'b10,
		CSPC_MODE_TXRX = 2'b11
	} cspc_mode_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} cspc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cspc_apb_rsp_t;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic so_o;
		logic so_oe;
	} cspc_pins_t;
endpackage : cspc_pkg

// [rtl/cspc_serial_port.sv]
// Purpose: register and control side of an 8-bit clocked serial port behind apb
// Assumes: pclk is the instruction cycle; shift_clock_pin input is asynchronous
// Notes:   write-only registers read as zero; no wait state on any access
`timescale 1ns/1ps

module cspc_serial_port
	import cspc_pkg::*;
(
	input  wire logic                    pclk,            // 20 MHz instruction clock
	input  wire logic                    presetn,         // async reset, active low
	input  wire cspc_pkg::cspc_apb_req_t apb_req,         // apb request
	output cspc_pkg::cspc_apb_rsp_t      apb_rsp,         // apb answer
	input  wire logic                    sck_i,           // shift_clock_pin level
	input  wire logic                    si_i,            // serial_in_pin level
	output cspc_pkg::cspc_pins_t         pins,            // clock and data pin drive
	output logic [1:0]                   so_pull_ctrl,    // pull-up control of serial_out_pin
	output logic                         serial_done_flag // transfer-complete flag
);
	import cspc_pkg::*;

	typedef struct packed {
		cspc_state_t st;
		logic [2:0]  cnt;
		logic [7:0]  sr;
		logic        sck;
		logic [12:0] div;
		logic [3:0]  sma;
		logic [3:0]  sma_eff;
		logic [1:0]  dly;
		logic [1:0]  smb;
		logic [1:0]  pmr;
		logic [1:0]  misc_pin_control;
		logic        flag;
		logic        so;
		logic [2:0]  sync;
		logic        elvl;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cspc_regs_t;

	cspc_regs_t  r_reg;
	cspc_regs_t  r_next;
	logic [11:0] idx;
	logic        setup;
	logic        wr;
	logic        ext_clk;
	logic [12:0] half;
	logic        tog;
	logic        rise;
	logic        fall;
	logic        first_low;
	logic        hit;
	logic [3:0]  shamt;

	assign idx   = apb_req.paddr[13:2];
	assign setup = apb_req.psel && !apb_req.penable;
	assign wr    = apb_req.psel && apb_req.penable && r_reg.pready && apb_req.pwrite && !r_reg.pslverr;

	// codes 6 and 7 of the divider field select the pin as clock source
	assign ext_clk = (r_reg.sma_eff[2:0] >= EXT_CLK_CODE);
	assign shamt   = 4'(HALF_LOG_MAX) - {r_reg.sma_eff[2:0], 1'b0} + {3'h0, r_reg.smb[0]};
	assign half    = 13'h0001 << shamt;
	assign tog     = !ext_clk && (r_reg.st != CSPC_WAIT_START) && (r_reg.div == half - 13'h0001);
	// clock ignored while waiting for start, and blocked by a mode write
	assign rise    = (r_reg.st != CSPC_WAIT_START) &&
	                 (ext_clk ? (r_reg.sync[1] == r_reg.sync[2] && r_reg.sync[2] && !r_reg.elvl)
	                          : (tog && !r_reg.sck));
	assign fall    = (r_reg.st != CSPC_WAIT_START) &&
	                 (ext_clk ? (r_reg.sync[1] == r_reg.sync[2] && !r_reg.sync[2] && r_reg.elvl)
	                          : (tog && r_reg.sck));
	assign first_low = (r_reg.st == CSPC_XFER) && (r_reg.cnt == 3'h0);
	assign hit       = (idx == IDX_FLAGS) || (idx == IDX_PORT_MODE_A) || (idx == IDX_SERIAL_A) ||
	                   (idx == IDX_SHIFT_LOW) || (idx == IDX_SHIFT_HIGH) || (idx == IDX_MISC_PIN) ||
	                   (idx == IDX_SERIAL_B) || (idx == IDX_START);

	always_comb begin
		r_next = r_reg;

		// pin synchroniser: only the agreeing later stages are looked at
		r_next.sync = {r_reg.sync[1:0], sck_i};
		if (r_reg.sync[1] == r_reg.sync[2]) begin
			r_next.elvl = r_reg.sync[2];
		end

		// mode value becomes active two cycles after its write
		if (r_reg.dly != 2'h0) begin
			r_next.dly = r_reg.dly - 2'h1;
			if (r_reg.dly == 2'h1) begin
				r_next.sma_eff = r_reg.sma;
			end
		end

		// internal shift clock from the prescaler
		if (!ext_clk && r_reg.st != CSPC_WAIT_START) begin
			r_next.div = tog ? 13'h0000 : r_reg.div + 13'h0001;
			if (tog) begin
				r_next.sck = !r_reg.sck;
			end
		end

		if (fall) begin
			if (r_reg.pmr[0]) begin
				r_next.so = r_reg.sr[0];
			end
			if (r_reg.st == CSPC_WAIT_CLK) begin
				r_next.st = (!ext_clk && r_reg.pmr == CSPC_MODE_CONT) ? CSPC_CONT : CSPC_XFER;
			end
		end

		if (rise && r_reg.st != CSPC_CONT) begin
			r_next.sr  = {(r_reg.pmr[1] ? si_i : 1'b0), r_reg.sr[7:1]};
			r_next.cnt = r_reg.cnt + 3'h1;
			if (r_reg.cnt == LAST_BIT) begin
				r_next.cnt  = 3'h0;
				r_next.flag = 1'b1;
				r_next.st   = ext_clk ? CSPC_WAIT_CLK : CSPC_WAIT_START;
				r_next.sck  = 1'b1;
				r_next.div  = 13'h0000;
			end
		end

		// apb answer in the first access cycle, no wait state
		r_next.pready = setup;
		if (setup) begin
			r_next.pslverr = !hit;
			r_next.prdata  = 32'h0000_0000;
			if (!apb_req.pwrite) begin
				if (idx == IDX_FLAGS) begin
					r_next.prdata[FLAG_DONE_BIT] = r_reg.flag;
					r_next.prdata[FLAG_STATE_LSB +: 2] = r_reg.st;
				end else if (idx == IDX_SHIFT_LOW) begin
					r_next.prdata[3:0] = r_reg.sr[3:0];
				end else if (idx == IDX_SHIFT_HIGH) begin
					r_next.prdata[3:0] = r_reg.sr[7:4];
				end
			end
		end else if (!apb_req.psel) begin
			r_next.pslverr = 1'b0;
		end

		if (wr) begin
			if (idx == IDX_FLAGS) begin
				// write one clears; a hardware set in the same cycle wins
				if (apb_req.pwdata[FLAG_DONE_BIT] && !r_next.flag) begin
					r_next.flag = 1'b0;
				end else if (apb_req.pwdata[FLAG_DONE_BIT] && r_reg.flag && !(rise && r_reg.cnt == LAST_BIT)) begin
					r_next.flag = 1'b0;
				end
			end else if (idx == IDX_PORT_MODE_A) begin
				r_next.pmr = apb_req.pwdata[1:0];
			end else if (idx == IDX_SERIAL_A) begin
				r_next.sma = apb_req.pwdata[3:0];
				r_next.dly = SERIAL_A_DLY;
				r_next.cnt = 3'h0;
				r_next.st  = CSPC_WAIT_START;
				r_next.sck = 1'b1;
				r_next.div = 13'h0000;
				if (r_reg.st == CSPC_XFER && !(first_low && !r_reg.sck)) begin
					r_next.flag = 1'b1;
				end
			end else if (idx == IDX_SHIFT_LOW) begin
				r_next.sr[3:0] = apb_req.pwdata[3:0];
			end else if (idx == IDX_SHIFT_HIGH) begin
				r_next.sr[7:4] = apb_req.pwdata[3:0];
			end else if (idx == IDX_MISC_PIN) begin
				r_next.misc_pin_control = apb_req.pwdata[1:0];
			end else if (idx == IDX_SERIAL_B) begin
				r_next.smb = apb_req.pwdata[1:0];
				if (r_reg.st == CSPC_WAIT_START) begin
					r_next.so = apb_req.pwdata[1];
				end
			end else if (idx == IDX_START) begin
				r_next.cnt = 3'h0;
				r_next.st  = CSPC_WAIT_CLK;
				r_next.sck = 1'b1;
				r_next.div = 13'h0000;
				if (r_reg.st == CSPC_XFER && !(first_low && !r_reg.sck)) begin
					r_next.flag = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg         <= '0;
			r_reg.st      <= CSPC_WAIT_START;
			r_reg.sck     <= 1'b1;
			r_reg.sma     <= SERIAL_A_RST;
			r_reg.sma_eff <= SERIAL_A_RST;
			r_reg.pmr     <= PORT_MODE_RST;
			r_reg.misc_pin_control     <= MISC_PIN_RST;
			r_reg.smb     <= SERIAL_B_RST;
			r_reg.sync    <= 3'h7;
			r_reg.elvl    <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// pin drive: flopped from r_next, with decode on the sck_oe path and gating on pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins             <= '0;
			so_pull_ctrl     <= MISC_PIN_RST;
			serial_done_flag <= 1'b0;
			apb_rsp          <= '0;
		end else begin
			pins.sck_o       <= r_next.sck;
			pins.sck_oe      <= r_next.sma_eff[3] && (r_next.sma_eff[2:0] < EXT_CLK_CODE);
			pins.so_o        <= r_next.so;
			pins.so_oe       <= r_next.pmr[0];
			so_pull_ctrl     <= r_next.misc_pin_control;
			serial_done_flag <= r_next.flag;
			apb_rsp.prdata   <= r_next.prdata;
			apb_rsp.pready   <= r_next.pready;
			apb_rsp.pslverr  <= r_next.pslverr && r_next.pready;
		end
	end
endmodule : cspc_serial_port

// [testbench/cspc_props.sv]
// Purpose: port checks on the serial port block
// Assumes: pready answers in the cycle after setup
// Notes:   flag read may race a set at the same edge
`timescale 1ns/1ps
module cspc_props
	import cspc_pkg::*;
(
	input wire logic               pclk,            // clock
	input wire logic               presetn,         // reset, active low
	input cspc_pkg::cspc_apb_req_t apb_req,         // apb request
	input cspc_pkg::cspc_apb_rsp_t apb_rsp,         // apb answer
	input cspc_pkg::cspc_pins_t    pins,            // pin drive
	input wire logic [1:0]         so_pull_ctrl,    // pull-up control
	input wire logic               serial_done_flag // done flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [11:0] idx;
	logic        wo, mapped, wr_ok;
	assign idx = apb_req.paddr[13:2];
	assign wo = idx inside {IDX_PORT_MODE_A, IDX_SERIAL_A, IDX_MISC_PIN, IDX_SERIAL_B};
	assign mapped = wo || idx inside {IDX_FLAGS, IDX_SHIFT_LOW, IDX_SHIFT_HIGH, IDX_START};
	assign wr_ok = apb_rsp.pready && apb_req.pwrite;
	sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
	sequence s_answer; apb_req.penable && apb_rsp.pready; endsequence
	a_answer_after_setup: assert property (s_setup |=> s_answer) else $error("no answer after setup");
	a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
	a_unmapped_err: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped) else $error("bad pslverr");
	a_wo_read_zero: assert property (apb_rsp.pready && !apb_req.pwrite && wo |-> apb_rsp.prdata == 32'h0)
		else $error("write-only read not zero");
	a_pull_follows: assert property (wr_ok && idx == IDX_MISC_PIN |=> so_pull_ctrl == $past(apb_req.pwdata[1:0]))
		else $error("pull control not written");
	a_so_on_fall: assert property ($changed(pins.so_o) && pins.sck_oe
		|-> !pins.sck_o || $past(wr_ok) || serial_done_flag) else $error("output moved while clock high");
	a_clock_rests_high: assert property ($rose(serial_done_flag) && pins.sck_oe && !$past(apb_rsp.pready)
		&& !$past(apb_rsp.pready, 2) |-> pins.sck_o [*8]) else $error("clock not stopped high");
	a_flag_read: assert property (apb_rsp.pready && !apb_req.pwrite && idx == IDX_FLAGS
		|-> apb_rsp.prdata[FLAG_DONE_BIT] == $past(serial_done_flag)) else $error("flag read mismatch");
endmodule : cspc_props

bind cspc_serial_port cspc_props u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.pins(pins), .so_pull_ctrl(so_pull_ctrl), .serial_done_flag(serial_done_flag));

// [testbench/cspc_partner.sv]
// Purpose: far-side serial peer
// Assumes: clock idles high
// Notes:   data line flips after each frame's hold
`timescale 1ns/1ps
module cspc_partner (
	input wire logic       pclk,  // bench clock
	input wire logic       run,   // one external frame
	input wire logic [7:0] tx,    // byte to send
	input wire logic       sck,   // clock wire
	input wire logic       so,    // output wire
	output logic           sck_o, // external clock
	output logic           si,    // data to port
	output logic [7:0]     rx     // byte taken
);
	logic [2:0] k = 3'h0;
	initial sck_o = 1'b1;
	initial si = 1'b0;
	initial rx = 8'h00;
	always @(posedge run) begin
		repeat (8) begin
			repeat (8) @(posedge pclk);
			sck_o <= 1'b0;
			repeat (8) @(posedge pclk);
			sck_o <= 1'b1;
		end
	end
	always @(negedge sck) begin
		si <= tx[k];
		k <= k + 3'h1;
	end
	always @(posedge sck) begin
		rx <= {so, rx[7:1]};
		if (k == 3'h0) begin
			repeat (6) @(posedge pclk);
			si <= ~si;
		end
	end
endmodule : cspc_partner

// [testbench/cspc_serial_port_bench.sv]
// Purpose: self-checking bench for the serial port block
// Assumes: peer drives the clock pin only in external mode
// Notes:   reads are queued and compared by a monitor
`timescale 1ns/1ps
module cspc_serial_port_bench;
	import cspc_pkg::*;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	cspc_apb_req_t req = '0;
	cspc_apb_rsp_t rsp;
	cspc_pins_t    pins;
	logic [1:0]    pull;
	logic          done, run = 1'b0, psck, psi, wsck, wso;
	logic [7:0]    ptx = 8'h00, prx, seed = 8'h47, d;
	logic [31:0]   exp_q[$];
	int            bad_count = 0, checked = 0;
	always #25 pclk = ~pclk;
	assign wsck = pins.sck_oe ? pins.sck_o : psck;
	assign wso = pins.so_oe ? pins.so_o : 1'b1; // pulled up when released
	cspc_serial_port dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .sck_i(wsck),
		.si_i(psi), .pins(pins), .so_pull_ctrl(pull), .serial_done_flag(done));
	cspc_partner peer (.pclk(pclk), .run(run), .tx(ptx), .sck(wsck), .so(wso), .sck_o(psck), .si(psi), .rx(prx));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic tally_and_finish();
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		// hold the request until pready is seen high at a rising edge
		do @(posedge pclk); while (rsp.pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin chk(32'h0, 32'h1); tally_and_finish(); end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, idx, 32'h0);
	endtask : rd
	task automatic wait_lv(input logic on_sck, input logic lv);
		int n;
		@(negedge pclk);
		for (n = 0; n < 5000 && (on_sck ? pins.sck_o : done) !== lv; n++) @(negedge pclk);
		if (n >= 5000) begin chk(32'h0, 32'h1); tally_and_finish(); end
	endtask : wait_lv
	// read data taken at the completing edge only
	always @(posedge pclk)
		if (rsp.pready === 1'b1 && req.psel === 1'b1 && req.penable === 1'b1 && req.pwrite === 1'b0)
			chk(rsp.prdata, exp_q.pop_front());
	task automatic xfer(input logic [1:0] pm, input logic [3:0] ma);
		seed = lfsr(seed);
		d = seed;
		seed = lfsr(seed);
		ptx <= seed;
		apb(1'b1, IDX_PORT_MODE_A, {30'h0, pm});
		apb(1'b1, IDX_SERIAL_A, {28'h0, ma});
		apb(1'b1, IDX_SHIFT_LOW, {28'h0, d[3:0]});
		apb(1'b1, IDX_SHIFT_HIGH, {28'h0, d[7:4]});
		apb(1'b1, IDX_START, 32'h0);
		run <= !ma[3];
		wait_lv(1'b0, 1'b1);
		if (pm[0]) chk({24'h0, prx}, {24'h0, d});
		rd(IDX_SHIFT_LOW, {28'h0, pm[1] ? ptx[3:0] : 4'h0});
		rd(IDX_SHIFT_HIGH, {28'h0, pm[1] ? ptx[7:4] : 4'h0});
		rd(IDX_FLAGS, ma[3] ? 32'h4 : 32'h14);
		apb(1'b1, IDX_FLAGS, 32'h4);
		run <= 1'b0;
	endtask : xfer
	initial begin
		logic [11:0] ro[5] = '{IDX_PORT_MODE_A, IDX_SERIAL_A, IDX_MISC_PIN, IDX_SERIAL_B, 12'h001};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ro[i]) rd(ro[i], 32'h0);
		chk({30'h0, pull}, 32'h0);
		apb(1'b1, IDX_MISC_PIN, 32'h3);
		@(negedge pclk);
		chk({30'h0, pull}, 32'h3);
		apb(1'b1, IDX_PORT_MODE_A, 32'h3);
		for (int v = 0; v < 2; v++) begin
			apb(1'b1, IDX_SERIAL_B, {30'h0, v[0], 1'b0});
			@(negedge pclk);
			chk({31'h0, pins.so_o}, {31'h0, v[0]});
		end
		$display("registers done");
		apb(1'b1, IDX_SERIAL_B, 32'h1);
		for (int p = 1; p < 4; p++) xfer(p[1:0], 4'hd);
		xfer(2'h3, 4'h6);
		$display("transfers done");
		apb(1'b1, IDX_SERIAL_A, 32'hc);
		for (int a = 0; a < 2; a++) begin
			apb(1'b1, IDX_START, 32'h0);
			wait_lv(1'b1, 1'b0);
			if (a == 1) wait_lv(1'b1, 1'b1);
			apb(1'b1, IDX_SERIAL_A, 32'hc);
			rd(IDX_FLAGS, a == 1 ? 32'h4 : 32'h0);
		end
		apb(1'b1, IDX_PORT_MODE_A, 32'h0);
		apb(1'b1, IDX_FLAGS, 32'h4);
		apb(1'b1, IDX_SERIAL_A, 32'hd);
		apb(1'b1, IDX_START, 32'h0);
		wait_lv(1'b1, 1'b0);
		rd(IDX_FLAGS, 32'h30);
		apb(1'b1, IDX_SERIAL_A, 32'hd);
		rd(IDX_FLAGS, 32'h0);
		$display("abort and continuous done");
		// second reset in mid-run: pull control and flag return to zero
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({30'h0, pull}, 32'h0);
		chk({31'h0, done}, 32'h0);
		presetn <= 1'b1;
		rd(IDX_FLAGS, 32'h0);
		$display("mid-run reset done");
		tally_and_finish();
	end
	initial begin
		#4000000;
		chk(32'h0, 32'h1);
		tally_and_finish();
	end
endmodule : cspc_serial_port_bench
